// file: logic/ccse_map.svh
// constants of the complement and compare-skip execution slice
// Summary of operation
// - complement opcode inverts register, sets N and Z
// - destination bit 0 gives accumulator, 1 register
// - bank bit 0 access window, 1 bank pointer
// - compare opcode subtracts, no flags, no store
// - equal operands discard fetched word, idle slot
// - compare is one word, one cycle, two or three when it skips
// - skipped two-word instruction costs three cycles total
`ifndef CCSE_MAP_SVH
`define CCSE_MAP_SVH

// opcode patterns on the upper instruction bits
`define CCSE_INV_OPC        6'h07
`define CCSE_INV_OPC_LSB    10
`define CCSE_CMP_OPC        7'h31
`define CCSE_CMP_OPC_LSB    9
`define CCSE_DEST_BIT       9
`define CCSE_BANK_BIT       8

// fixed access window: low half from bank 0, high half from the top bank
`define CCSE_WIN_SPLIT      8'h80
`define CCSE_WIN_LOW_BANK   4'h0
`define CCSE_WIN_HIGH_BANK  4'hF

// phases of one instruction cycle
`define CCSE_PH_DECODE      2'h0
`define CCSE_PH_READ        2'h1
`define CCSE_PH_PROCESS     2'h2
`define CCSE_PH_WRITE       2'h3

// register word indices on the bus
`define CCSE_REG_ACC        2'h0
`define CCSE_REG_BANK       2'h1
`define CCSE_REG_STAT       2'h2
`define CCSE_REG_SKIP       2'h3

// status register fields
`define CCSE_STAT_Z         0
`define CCSE_STAT_N         1
`define CCSE_STAT_BUSY      8

// reset values
`define CCSE_ACC_RST        8'h00
`define CCSE_BANK_RST       4'h0

// words discarded by a taken skip
`define CCSE_SKIP_ONE       2'h1
`define CCSE_SKIP_TWO       2'h2

`endif

// file: logic/ccse_pkg.sv
// types of the complement and compare-skip execution slice
package ccse_pkg;

    typedef enum logic [1:0] {
        CCSE_IDLE_S,
        CCSE_INV_S,
        CCSE_CMP_S,
        CCSE_SKIP_S
    } ccse_state_t;

endpackage : ccse_pkg

// file: logic/ccse_phase.sv
// four-phase sequencer of the instruction cycle
`timescale 1ns/1ps
`include "ccse_map.svh"

module ccse_phase
    import ccse_pkg::*;
(
    // clock and reset
    input  wire logic       clock_in,
    input  wire logic       rst_b_in,
    // phase
    output logic [1:0]      phase_out
);

    typedef struct packed {
        logic [1:0] phase;
    } ccse_phase_st_t;

    ccse_phase_st_t st_ff;
    ccse_phase_st_t nxt_st;

    always_comb begin
        nxt_st       = st_ff;
        nxt_st.phase = st_ff.phase + 2'h1;
    end

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            st_ff.phase <= `CCSE_PH_DECODE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign phase_out = st_ff.phase;

endmodule : ccse_phase

// file: logic/ccse_exec.sv
// execution slice for the register complement and equal compare-skip
//
// Implementation choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`include "ccse_map.svh"

module ccse_exec
    import ccse_pkg::*;
(
    // clock and reset
    input  wire logic        clock_in,
    input  wire logic        rst_b_in,
    // instruction handed over by the fetch pipeline
    input  wire logic        insn_valid_in,
    input  wire logic [15:0] insn_word_in,
    input  wire logic        fetched_two_word_in,
    // data memory
    output logic [11:0]      mem_addr_out,
    output logic             mem_rd_out,
    input  wire logic [7:0]  mem_rdata_in,
    output logic             mem_wr_out,
    output logic [7:0]       mem_wdata_out,
    // execution status
    output logic             exec_out,
    output logic             discard_out,
    // avalon-mm slave
    input  wire logic [1:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic [31:0]      avs_readdata_out,
    output logic             avs_waitrequest_out
);

    typedef struct packed {
        ccse_state_t state;
        logic        dest_reg;
        logic [7:0]  res;
        logic        eq;
        logic [1:0]  skip_cnt;
        logic [11:0] addr;
        logic        rd;
        logic        wr;
        logic [7:0]  wdata;
        logic [7:0]  acc;
        logic [3:0]  bank;
        logic        flag_n;
        logic        flag_z;
        logic [7:0]  skip_total;
        logic        exec;
        logic        discard;
        logic        wreq;
        logic [31:0] rdata;
    } ccse_st_t;

    ccse_st_t   st_ff;
    ccse_st_t   nxt_st;
    logic [1:0] phase;

    ccse_phase u_phase (
        .clock_in  (clock_in),
        .rst_b_in  (rst_b_in),
        .phase_out (phase)
    );

    function automatic logic [11:0] data_addr(input logic       use_bank,
                                               input logic [3:0] bank,
                                               input logic [7:0] f);
        logic [3:0] hi;
        hi = (f < `CCSE_WIN_SPLIT) ? `CCSE_WIN_LOW_BANK : `CCSE_WIN_HIGH_BANK;
        if (use_bank) begin
            return {bank, f};
        end
        return {hi, f};
    endfunction : data_addr

    function automatic logic [7:0] invert_byte(input logic [7:0] v);
        return ~v;
    endfunction : invert_byte

    logic       is_inv;
    logic       is_cmp;
    logic       bus_go;
    logic       sw_write;
    logic [7:0] diff;

    assign is_inv   = (insn_word_in[15:`CCSE_INV_OPC_LSB] == `CCSE_INV_OPC);
    assign is_cmp   = (insn_word_in[15:`CCSE_CMP_OPC_LSB] == `CCSE_CMP_OPC);
    assign bus_go   = (avs_read_in || avs_write_in) && st_ff.wreq;
    // a write lands only on the edge that sees waitrequest low
    assign sw_write = avs_write_in && !st_ff.wreq && avs_byteenable_in[0];
    assign diff     = mem_rdata_in - st_ff.acc;

    always_comb begin
        nxt_st         = st_ff;
        nxt_st.rd      = 1'b0;
        nxt_st.wr      = 1'b0;
        nxt_st.wreq    = 1'b1;

        // bus side: one wait cycle, then answer; the core's own update of
        // acc and flags in the same cycle wins over a software write below
        if (bus_go) begin
            nxt_st.wreq = 1'b0;
            case (avs_address_in)
                `CCSE_REG_ACC: begin
                    nxt_st.rdata = {24'h000000, st_ff.acc};
                end
                `CCSE_REG_BANK: begin
                    nxt_st.rdata = {28'h0000000, st_ff.bank};
                end
                `CCSE_REG_STAT: begin
                    nxt_st.rdata = 32'h00000000;
                    nxt_st.rdata[`CCSE_STAT_Z]    = st_ff.flag_z;
                    nxt_st.rdata[`CCSE_STAT_N]    = st_ff.flag_n;
                    // busy lets software see an instruction or idle slot in flight
                    nxt_st.rdata[`CCSE_STAT_BUSY] = (st_ff.state != CCSE_IDLE_S);
                end
                `CCSE_REG_SKIP: begin
                    nxt_st.rdata = {24'h000000, st_ff.skip_total};
                end
                default: begin
                    nxt_st.rdata = 32'h00000000;
                end
            endcase
        end
        if (sw_write) begin
            case (avs_address_in)
                `CCSE_REG_ACC: begin
                    nxt_st.acc = avs_writedata_in[7:0];
                end
                `CCSE_REG_BANK: begin
                    nxt_st.bank = avs_writedata_in[3:0];
                end
                `CCSE_REG_STAT: begin
                    nxt_st.flag_z = avs_writedata_in[`CCSE_STAT_Z];
                    nxt_st.flag_n = avs_writedata_in[`CCSE_STAT_N];
                end
                `CCSE_REG_SKIP: begin
                    nxt_st.skip_total = 8'h00;
                end
                default: ;
            endcase
        end

        case (phase)
            `CCSE_PH_DECODE: begin
                nxt_st.exec    = 1'b0;
                nxt_st.discard = 1'b0;
                nxt_st.state   = CCSE_IDLE_S;
                if (st_ff.skip_cnt != 2'h0) begin
                    // fetched word dropped, idle slot runs in its place
                    nxt_st.state    = CCSE_SKIP_S;
                    nxt_st.discard  = 1'b1;
                    nxt_st.skip_cnt = st_ff.skip_cnt - 2'h1;
                end else if (insn_valid_in && (is_inv || is_cmp)) begin
                    nxt_st.state    = is_inv ? CCSE_INV_S : CCSE_CMP_S;
                    nxt_st.dest_reg = insn_word_in[`CCSE_DEST_BIT];
                    nxt_st.addr     = data_addr(insn_word_in[`CCSE_BANK_BIT],
                                                st_ff.bank, insn_word_in[7:0]);
                    nxt_st.rd       = 1'b1;
                    nxt_st.exec     = 1'b1;
                end
            end
            `CCSE_PH_READ: begin
                // memory answers in the cycle after the read strobe
            end
            `CCSE_PH_PROCESS: begin
                nxt_st.res = invert_byte(mem_rdata_in);
                nxt_st.eq  = (diff == 8'h00);
                // memory write goes out a clock before acc and flags settle
                if (st_ff.state == CCSE_INV_S && st_ff.dest_reg) begin
                    nxt_st.wr    = 1'b1;
                    nxt_st.wdata = invert_byte(mem_rdata_in);
                end
            end
            `CCSE_PH_WRITE: begin
                case (st_ff.state)
                    CCSE_INV_S: begin
                        if (!st_ff.dest_reg) begin
                            nxt_st.acc = st_ff.res;
                        end
                        nxt_st.flag_n = st_ff.res[7];
                        nxt_st.flag_z = (st_ff.res == 8'h00);
                    end
                    CCSE_CMP_S: begin
                        if (st_ff.eq) begin
                            if (fetched_two_word_in) begin
                                nxt_st.skip_cnt = `CCSE_SKIP_TWO;
                            end else begin
                                nxt_st.skip_cnt = `CCSE_SKIP_ONE;
                            end
                            // a clear on this edge still keeps the skip it raced with
                            nxt_st.skip_total = nxt_st.skip_total + 8'h01;
                        end
                    end
                    default: ;
                endcase
            end
            default: ;
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            st_ff            <= '0;
            st_ff.state      <= CCSE_IDLE_S;
            st_ff.acc        <= `CCSE_ACC_RST;
            st_ff.bank       <= `CCSE_BANK_RST;
            st_ff.wreq       <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign mem_addr_out        = st_ff.addr;
    assign mem_rd_out          = st_ff.rd;
    assign mem_wr_out          = st_ff.wr;
    assign mem_wdata_out       = st_ff.wdata;
    assign exec_out            = st_ff.exec;
    assign discard_out         = st_ff.discard;
    assign avs_readdata_out    = st_ff.rdata;
    assign avs_waitrequest_out = st_ff.wreq;

endmodule : ccse_exec

// file: tb/ccse_exec_chk.sv
// port assertions of the execution slice
`timescale 1ns/1ps
module ccse_exec_chk (
    // clock and reset
    input wire logic       clock_in,
    input wire logic       rst_b_in,
    // watched ports
    input wire logic       avs_read_in,
    input wire logic       avs_write_in,
    input wire logic       avs_waitrequest_out,
    input wire logic       mem_rd_out,
    input wire logic [7:0] mem_rdata_in,
    input wire logic       mem_wr_out,
    input wire logic [7:0] mem_wdata_out,
    input wire logic       exec_out,
    input wire logic       discard_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);
    rd_pulse_a: assert property (mem_rd_out |=> !mem_rd_out [*3])
        else $error("read strobe repeats inside one cycle");
    wr_after_rd_a: assert property (mem_wr_out |-> $past(mem_rd_out, 2))
        else $error("write not two clocks after read");
    wr_data_a: assert property (mem_wr_out |-> mem_wdata_out == ~$past(mem_rdata_in))
        else $error("written value is not the inverse");
    rd_in_exec_a: assert property (mem_rd_out || mem_wr_out |-> exec_out)
        else $error("memory strobe outside an executed cycle");
    exec_len_a: assert property ($rose(exec_out) |-> exec_out [*4])
        else $error("executed cycle shorter than four clocks");
    disc_len_a: assert property ($rose(discard_out) |-> discard_out [*4])
        else $error("idle slot shorter than four clocks");
    disc_excl_a: assert property (discard_out |-> !exec_out && !mem_rd_out && !mem_wr_out)
        else $error("idle slot touches memory");
    bus_answer_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
        |=> !avs_waitrequest_out) else $error("bus request not answered next cycle");
    wait_once_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest low for more than one cycle");
    cover property ($rose(discard_out));
    cover property (mem_wr_out);
    cover property (!avs_waitrequest_out && avs_read_in);
endmodule : ccse_exec_chk

// file: tb/testbench.sv
// self-checking bench of the execution slice
`timescale 1ns/1ps
`include "ccse_map.svh"
module testbench;
    logic        clock_in = 1'b0;
    logic        rst_b_in = 1'b0;
    logic        insn_valid_in = 1'b0;
    logic [15:0] insn_word_in = 16'h0000;
    logic        fetched_two_word_in = 1'b0;
    logic [7:0]  mem_rdata_in = 8'h00;
    logic [1:0]  avs_address_in = 2'h0;
    logic        avs_read_in = 1'b0;
    logic        avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0;
    logic [3:0]  avs_byteenable_in = 4'hF;
    logic [11:0] mem_addr_out;
    logic        mem_rd_out, mem_wr_out, exec_out, discard_out, avs_waitrequest_out;
    logic [7:0]  mem_wdata_out;
    logic [31:0] avs_readdata_out, q;
    logic [1:0]  ph = 2'h0;
    logic [7:0]  lf = 8'h31;
    int          n_errors = 0, checks_done = 0, cyc = 0, acc, bank, nf, zf, skips;
    int          wq[$];
    ccse_exec uut (.clock_in, .rst_b_in, .insn_valid_in, .insn_word_in, .fetched_two_word_in,
        .mem_addr_out, .mem_rd_out, .mem_rdata_in, .mem_wr_out, .mem_wdata_out, .exec_out,
        .discard_out, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
        .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out);
    always #4 clock_in = ~clock_in;
    // ph holds the phase of the coming edge; hang guard well above the run length
    always @(posedge clock_in) begin
        ph <= rst_b_in ? ph + 2'h1 : 2'h0;
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            report_and_stop();
        end
    end
    function automatic logic [7:0] rnd();
        lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
        return lf;
    endfunction : rnd
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [1:0] a, input logic [31:0] d);
        @(posedge clock_in);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_read_in <= !wr;
        avs_write_in <= wr;
        do @(posedge clock_in); while (avs_waitrequest_out !== 1'b0);
        q = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
    endtask : bus
    task automatic run(input logic [15:0] w, input int ea, input int ewr, input int edisc);
        int nrd = 0, nwr = 0, nex = 0, nd = 0;
        logic [11:0] ad = 12'h000;
        logic [7:0] wd = 8'h00;
        do @(posedge clock_in); while (ph !== 2'h3);
        insn_valid_in <= 1'b1;
        insn_word_in <= w;
        @(posedge clock_in);
        insn_valid_in <= 1'b0;
        repeat (16) begin
            @(negedge clock_in);
            nrd += (mem_rd_out === 1'b1);
            nwr += (mem_wr_out === 1'b1);
            nex += (exec_out === 1'b1);
            nd += (discard_out === 1'b1);
            if (mem_rd_out === 1'b1) ad = mem_addr_out;
            if (mem_wr_out === 1'b1) wd = mem_wdata_out;
        end
        chk(nrd, ea >= 0, "reads");
        chk(nex, ea >= 0 ? 4 : 0, "exec clocks");
        chk(nwr, ewr, "writes");
        chk(nd, 4 * edisc, "idle clocks");
        if (ea >= 0) chk(ad, ea, "address");
        if (ewr != 0) chk(wd, wq.pop_front(), "write data");
    endtask : run
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (12) @(posedge clock_in);
        rst_b_in <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            bus(1'b0, i[1:0], 32'h0);
            chk(q, 32'h0, "reset value");
        end
        // a write without byte lane 0 leaves the accumulator alone
        avs_byteenable_in <= 4'h0;
        bus(1'b1, `CCSE_REG_ACC, 32'h5A);
        avs_byteenable_in <= 4'hF;
        bus(1'b0, `CCSE_REG_ACC, 32'h0);
        chk(q, 32'h0, "masked write");
        acc = 0; nf = 0; zf = 0; skips = 0;
        for (int i = 0; i < 24; i++) begin
            int op, d, a, f, r, ea, dis;
            op = i % 3;
            d = (i / 3) % 2;
            a = (i / 6) % 2;
            f = rnd();
            acc = rnd();
            bank = rnd() % 16;
            r = (op == 1 && i % 2 == 1) ? acc : rnd();
            bus(1'b1, `CCSE_REG_ACC, acc);
            bus(1'b1, `CCSE_REG_BANK, bank);
            mem_rdata_in <= r[7:0];
            fetched_two_word_in <= (i % 4 > 1);
            ea = a ? bank * 256 + f : (f < 8'h80 ? f : 12'hF00 + f);
            dis = (op == 1 && r == acc) ? 1 + (i % 4 > 1) : 0;
            skips += (dis > 0);
            if (op == 0) begin
                nf = (~r >> 7) & 1;
                zf = (r == 255);
                if (d == 0) acc = ~r & 255;
                if (d == 1) wq.push_back(~r & 255);
            end
            run(op == 0 ? {6'h07, d[0], a[0], f[7:0]} : op == 1 ? {7'h31, a[0], f[7:0]}
                : {8'h00, f[7:0]}, op == 2 ? -1 : ea, op == 0 && d == 1, dis);
            bus(1'b0, `CCSE_REG_ACC, 32'h0);
            chk(q, acc, "accumulator");
            bus(1'b0, `CCSE_REG_STAT, 32'h0);
            chk({q[`CCSE_STAT_N], q[`CCSE_STAT_Z]}, {nf[0], zf[0]}, "flags");
            bus(1'b0, `CCSE_REG_SKIP, 32'h0);
            chk(q, skips, "skip count");
            $display("test %0d done, kind %0d", i, op);
        end
        // software side of the status, skip and bank words
        bus(1'b1, `CCSE_REG_STAT, 32'h3);
        bus(1'b0, `CCSE_REG_STAT, 32'h0);
        chk(q, 32'h3, "status write");
        bus(1'b1, `CCSE_REG_SKIP, 32'h0);
        bus(1'b0, `CCSE_REG_SKIP, 32'h0);
        chk(q, 32'h0, "skip clear");
        bus(1'b0, `CCSE_REG_BANK, 32'h0);
        chk(q, bank, "bank readback");
        $display("test register access done");
        report_and_stop();
    end
endmodule : testbench
bind ccse_exec ccse_exec_chk chk_i (.clock_in, .rst_b_in, .avs_read_in, .avs_write_in,
    .avs_waitrequest_out, .mem_rd_out, .mem_rdata_in, .mem_wr_out, .mem_wdata_out, .exec_out,
    .discard_out);
